/* File: core/rxe_cfg.svh */
`ifndef RXE_CFG_SVH
`define RXE_CFG_SVH
// wishbone register byte offsets
`define RXE_OFS_EVENT 8'h00
`define RXE_OFS_VBASE 8'h04
`define RXE_OFS_STATUS 8'h08
`define RXE_OFS_FAULT 8'h0c
`define RXE_OFS_PAGE_HI 8'h10
`define RXE_OFS_SAVED_PC 8'h14
`define RXE_OFS_SAVED_ST 8'h18
`define RXE_OFS_SAVED_GR 8'h1c
`define RXE_OFS_PC 8'h20
`define RXE_OFS_WDT 8'h24
`define RXE_OFS_DBG 8'h28
// event codes
`define RXE_CODE_POR 12'h000
`define RXE_CODE_MAN 12'h020
`define RXE_CODE_MISS_RD 12'h040
`define RXE_CODE_MISS_WR 12'h060
`define RXE_CODE_MHIT 12'h140
// addresses and offsets
`define RXE_RESET_VEC 32'ha0000000
`define RXE_MISS_OFS 32'h00000400
`define RXE_VBASE_RST 32'h00000000
// status word field positions
`define RXE_SW_PRIV 30
`define RXE_SW_BANK 29
`define RXE_SW_BLOCK 28
`define RXE_SW_FPU_DIS 15
`define RXE_SW_MASK_HI 7
`define RXE_SW_MASK_LO 4
`define RXE_MASK_ALL 4'hf
`define RXE_SW_RST 32'h700000f0
// watchdog control bits
`define RXE_WDT_MODE 1
`define RXE_WDT_RSEL 0
// debug instruction codes and page number low bit position
`define RXE_DBG_NEG 4'h6
`define RXE_DBG_ASR 4'h7
`define RXE_PAGE_NUM_LO 10
`endif

/* File: core/rxe_entry.sv */
// How it works
// [RULE_01] watchdog overflow, timer mode 1, reset-select 0: power-on reset
// [RULE_02] watchdog overflow with reset-select 1: manual reset
// [RULE_03] general exception while block bit set: manual reset instead
// [RULE_04] manual pin low with power-on pin high: manual reset
// [RULE_05] power-on reset writes code 000 and full initialisation
// [RULE_06] manual reset writes code 020 and manual initialisation
// [RULE_07] resets clear vector base, set mode/bank/block, clear fpu-disable, mask all ones
// [RULE_08] every reset loads pc with a0000000
// [RULE_09] debug codes 0110 or 0111 cause power-on style reset, code 000
// [RULE_10] instruction buffer multiple hit: reset with code 140
// [RULE_11] unified buffer multiple hit: reset with code 140
// [RULE_12] multiple hits initialise like a manual reset
// [RULE_13] fault address stored, page number into page-entry-high 31:10, id kept
// [RULE_14] unified buffer miss jumps to vector base plus 400
// [RULE_15] miss writes code 040 on read, 060 on write
// [RULE_16] miss saves pc, status word and general register 15
// [RULE_17] miss sets block, mode, bank bits; vector base and mask unchanged
// [RULE_18] system holds test reset low with power-on reset at power-up
// [RULE_19] system releases power-on pin no earlier than manual pin
// [RULE_20] event register holds 12-bit code, hardware set, software writable
`include "rxe_cfg.svh"
module rxe_entry (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // reset pins, asynchronous
  input wire logic i_por_rst_n,
  input wire logic i_manual_rst_n,
  // internal event sources
  input wire logic i_wdt_overflow,
  input wire logic i_gen_exc,
  input wire logic i_user_break,
  input wire logic i_instr_xlate_buffer_multi_hit,
  input wire logic i_unified_xlate_buffer_multi_hit,
  input wire logic i_unified_xlate_buffer_miss,
  input wire rxe_pkg::rxe_fault_s i_fault,
  // wishbone slave
  input wire rxe_pkg::rxe_wb_req_s i_wb,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // redirect and initialisation
  output logic o_pc_load,
  output logic [31:0] o_pc,
  output logic o_init_por,
  output logic o_init_manual,
  output logic [31:0] o_status_word
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    rxe_pkg::rxe_state_e st;
    logic [11:0] exc_event_code;
    logic [31:0] vector_base;
    logic [31:0] status_word;
    logic [31:0] fault_address_reg;
    logic [31:0] page_entry_high;
    logic [31:0] saved_pc;
    logic [31:0] saved_status;
    logic [31:0] saved_gr15;
    logic [31:0] pc;
    logic [1:0] wdt_ctrl_status;
    logic [3:0] debug_instr_code;
    logic pc_load;
    logic init_por;
    logic init_manual;
    logic [31:0] wb_dat;
    logic wb_ack;
  } rxe_state_s;

  rxe_state_s s_r;
  rxe_state_s s_nxt;
  logic [1:0] pins_sync;
  logic por_pin;
  logic man_pin;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  rxe_sync2 #(.W(2)) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async({i_por_rst_n, i_manual_rst_n}),
    .o_sync(pins_sync)
  );
  assign por_pin = pins_sync[1];
  assign man_pin = pins_sync[0];

  // ------------------------------------------------------------
  // event decode
  // ------------------------------------------------------------
  logic wdt_por;
  logic wdt_man;
  logic blk_man;
  logic dbg_rst;
  logic any_por;
  logic any_man;
  logic any_mhit;
  logic miss_take;
  logic wb_go;
  logic [31:0] sr_rst;
  logic [31:0] wmask;

  always_comb begin
    wdt_por = i_wdt_overflow && s_r.wdt_ctrl_status[`RXE_WDT_MODE]
      && !s_r.wdt_ctrl_status[`RXE_WDT_RSEL]; // RULE_01
    wdt_man = i_wdt_overflow && s_r.wdt_ctrl_status[`RXE_WDT_RSEL]; // RULE_02
    // a miss is a general exception too, so a blocked one escalates
    blk_man = s_r.status_word[`RXE_SW_BLOCK]
      && ((i_gen_exc && !i_user_break) || (i_unified_xlate_buffer_miss && i_fault.valid)); // RULE_03
    dbg_rst = (s_r.debug_instr_code == `RXE_DBG_NEG)
      || (s_r.debug_instr_code == `RXE_DBG_ASR); // RULE_09
    any_por = !por_pin || wdt_por || dbg_rst;
    // manual pin only counts with power-on pin released
    any_man = (!man_pin && por_pin) || wdt_man || blk_man; // RULE_04
    any_mhit = i_instr_xlate_buffer_multi_hit || i_unified_xlate_buffer_multi_hit; // RULE_10 RULE_11
    // blocked misses are taken by blk_man above
    miss_take = i_unified_xlate_buffer_miss && i_fault.valid && !s_r.status_word[`RXE_SW_BLOCK];
    wb_go = i_wb.cyc && i_wb.stb && !s_r.wb_ack;
    wmask = {{8{i_wb.sel[3]}}, {8{i_wb.sel[2]}}, {8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};
    sr_rst = s_r.status_word;
    sr_rst[`RXE_SW_PRIV] = 1'b1; // RULE_07
    sr_rst[`RXE_SW_BANK] = 1'b1;
    sr_rst[`RXE_SW_BLOCK] = 1'b1;
    sr_rst[`RXE_SW_FPU_DIS] = 1'b0;
    sr_rst[`RXE_SW_MASK_HI:`RXE_SW_MASK_LO] = `RXE_MASK_ALL;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.pc_load = 1'b0;
    s_nxt.init_por = 1'b0;
    s_nxt.init_manual = 1'b0;
    s_nxt.wb_ack = 1'b0;
    s_nxt.wb_dat = s_r.wb_dat;

    // software access first; hardware events below override it
    if (wb_go) begin
      s_nxt.wb_ack = 1'b1;
      s_nxt.wb_dat = 32'h00000000;
      case (i_wb.adr)
        `RXE_OFS_EVENT: s_nxt.wb_dat = {20'h00000, s_r.exc_event_code};
        `RXE_OFS_VBASE: s_nxt.wb_dat = s_r.vector_base;
        `RXE_OFS_STATUS: s_nxt.wb_dat = s_r.status_word;
        `RXE_OFS_FAULT: s_nxt.wb_dat = s_r.fault_address_reg;
        `RXE_OFS_PAGE_HI: s_nxt.wb_dat = s_r.page_entry_high;
        `RXE_OFS_SAVED_PC: s_nxt.wb_dat = s_r.saved_pc;
        `RXE_OFS_SAVED_ST: s_nxt.wb_dat = s_r.saved_status;
        `RXE_OFS_SAVED_GR: s_nxt.wb_dat = s_r.saved_gr15;
        `RXE_OFS_PC: s_nxt.wb_dat = s_r.pc;
        `RXE_OFS_WDT: s_nxt.wb_dat = {30'h00000000, s_r.wdt_ctrl_status};
        `RXE_OFS_DBG: s_nxt.wb_dat = {28'h0000000, s_r.debug_instr_code};
        default: s_nxt.wb_dat = 32'h00000000;
      endcase
      if (i_wb.we) begin
        case (i_wb.adr)
          `RXE_OFS_EVENT: begin
            s_nxt.exc_event_code = (s_r.exc_event_code & ~wmask[11:0])
              | (i_wb.dat[11:0] & wmask[11:0]); // RULE_20
          end
          `RXE_OFS_VBASE: s_nxt.vector_base = (s_r.vector_base & ~wmask) | (i_wb.dat & wmask);
          `RXE_OFS_STATUS: s_nxt.status_word = (s_r.status_word & ~wmask) | (i_wb.dat & wmask);
          `RXE_OFS_PAGE_HI: begin
            s_nxt.page_entry_high = (s_r.page_entry_high & ~wmask) | (i_wb.dat & wmask);
          end
          `RXE_OFS_WDT: begin
            if (i_wb.sel[0]) s_nxt.wdt_ctrl_status = i_wb.dat[1:0];
          end
          `RXE_OFS_DBG: begin
            if (i_wb.sel[0]) s_nxt.debug_instr_code = i_wb.dat[3:0];
          end
          default: s_nxt.wb_ack = 1'b1;
        endcase
      end
    end

    case (s_r.st)
      rxe_pkg::RXE_ST_RUN: begin
        if (any_por) begin
          s_nxt.exc_event_code = `RXE_CODE_POR; // RULE_05 RULE_09
          s_nxt.init_por = 1'b1;
        end else if (any_man) begin
          s_nxt.exc_event_code = `RXE_CODE_MAN; // RULE_06
          s_nxt.init_manual = 1'b1;
        end else if (any_mhit) begin
          s_nxt.exc_event_code = `RXE_CODE_MHIT; // RULE_10 RULE_11
          s_nxt.init_manual = 1'b1; // RULE_12
          s_nxt.fault_address_reg = i_fault.vaddr; // RULE_13
          s_nxt.page_entry_high[31:`RXE_PAGE_NUM_LO] = i_fault.vaddr[31:`RXE_PAGE_NUM_LO];
        end else if (miss_take) begin
          s_nxt.fault_address_reg = i_fault.vaddr; // RULE_13
          s_nxt.page_entry_high[31:`RXE_PAGE_NUM_LO] = i_fault.vaddr[31:`RXE_PAGE_NUM_LO];
          s_nxt.exc_event_code = i_fault.is_write ? `RXE_CODE_MISS_WR
            : `RXE_CODE_MISS_RD; // RULE_15
          s_nxt.saved_pc = i_fault.pc; // RULE_16
          s_nxt.saved_status = s_r.status_word;
          s_nxt.saved_gr15 = i_fault.gr15;
          s_nxt.status_word[`RXE_SW_BLOCK] = 1'b1; // RULE_17
          s_nxt.status_word[`RXE_SW_PRIV] = 1'b1;
          s_nxt.status_word[`RXE_SW_BANK] = 1'b1;
          s_nxt.pc = s_r.vector_base + `RXE_MISS_OFS; // RULE_14
          s_nxt.pc_load = 1'b1;
        end
        if (any_por || any_man || any_mhit) begin
          s_nxt.vector_base = `RXE_VBASE_RST; // RULE_07
          s_nxt.status_word = sr_rst;
          s_nxt.pc = `RXE_RESET_VEC; // RULE_08
          s_nxt.pc_load = 1'b1;
          s_nxt.st = rxe_pkg::RXE_ST_HOLD;
        end
        if (any_por) begin
          // full init also drops watchdog and debug settings
          s_nxt.wdt_ctrl_status = 2'h0;
          s_nxt.debug_instr_code = 4'h0;
        end
      end
      rxe_pkg::RXE_ST_HOLD: begin
        // wait until pins release before accepting new entry
        if (por_pin && man_pin) s_nxt.st = rxe_pkg::RXE_ST_RUN;
      end
      default: s_nxt.st = rxe_pkg::RXE_ST_RUN;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_r <= '0;
      s_r.st <= rxe_pkg::RXE_ST_RUN;
      s_r.exc_event_code <= `RXE_CODE_POR;
      s_r.status_word <= `RXE_SW_RST;
      s_r.pc <= `RXE_RESET_VEC;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_wb_dat = s_r.wb_dat;
  assign o_wb_ack = s_r.wb_ack;
  assign o_pc_load = s_r.pc_load;
  assign o_pc = s_r.pc;
  assign o_init_por = s_r.init_por;
  assign o_init_manual = s_r.init_manual;
  assign o_status_word = s_r.status_word;
endmodule : rxe_entry

/* File: core/rxe_pkg.sv */
package rxe_pkg;
  typedef enum logic [1:0] {
    RXE_ST_RUN = 2'b00,
    RXE_ST_HOLD = 2'b01
  } rxe_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } rxe_wb_req_s;

  typedef struct packed {
    logic valid;
    logic [31:0] vaddr;
    logic is_write;
    logic [31:0] pc;
    logic [31:0] gr15;
  } rxe_fault_s;
endpackage : rxe_pkg

/* File: core/rxe_sync2.sv */
module rxe_sync2 #(
  parameter int W = 2
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  if (W < 1) begin : g_bad_width
    $error("rxe_sync2: width must be positive");
  end

  // pins idle high: reset to inactive level
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule : rxe_sync2

/* File: tb/rxe_entry_props.sv */
module rxe_entry_props (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // watched ports
  input wire logic i_por_rst_n,
  input wire logic i_manual_rst_n,
  input wire logic i_wdt_overflow,
  input wire logic i_gen_exc,
  input wire logic i_user_break,
  input wire logic i_instr_xlate_buffer_multi_hit,
  input wire logic i_unified_xlate_buffer_multi_hit,
  input wire logic i_unified_xlate_buffer_miss,
  input wire rxe_pkg::rxe_fault_s i_fault,
  input wire logic o_pc_load,
  input wire logic [31:0] o_pc,
  input wire logic o_init_por,
  input wire logic o_init_manual,
  input wire logic [31:0] o_status_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] q_r;
  logic [2:0] q_nxt;
  logic ini;
  logic mh;
  logic calm;
  assign ini = o_init_por | o_init_manual;
  assign mh = i_instr_xlate_buffer_multi_hit | i_unified_xlate_buffer_multi_hit;
  // hold state is hidden, so events are judged only well after an entry
  assign calm = q_r == 3'h7 && i_por_rst_n && i_manual_rst_n && !i_wdt_overflow;
  always_comb begin
    q_nxt = ini ? 3'h0 : q_r + {2'h0, q_r != 3'h7};
  end
  always_ff @(posedge i_clk) begin
    q_r <= i_rstn ? q_nxt : 3'h0;
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  property p_rst_pc; ini |-> o_pc_load && o_pc == 32'ha0000000; endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("reset pc");
  property p_rst_sr; ini |-> o_status_word[30:28] == 3'h7 && !o_status_word[15]
    && o_status_word[7:4] == 4'hf; endproperty
  a_rst_sr: assert property (p_rst_sr) else $error("reset status");
  property p_mhit; calm && mh |=> o_init_manual && !o_init_por; endproperty
  a_mhit: assert property (p_mhit) else $error("multi hit");
  property p_bl; calm && i_gen_exc && !i_user_break && o_status_word[28] |=> o_init_manual;
  endproperty
  a_bl: assert property (p_bl) else $error("blocked exception");
  property p_ubrk; calm && i_gen_exc && i_user_break && !mh |=> !ini; endproperty
  a_ubrk: assert property (p_ubrk) else $error("user break");
  property p_miss_bl; calm && i_unified_xlate_buffer_miss && i_fault.valid && o_status_word[28]
    |=> o_init_manual && !o_init_por; endproperty
  a_miss_bl: assert property (p_miss_bl) else $error("blocked miss");
  property p_man; $fell(i_manual_rst_n) && i_por_rst_n |-> ##[1:6] o_init_manual; endproperty
  a_man: assert property (p_man) else $error("manual pin");
  property p_por; $fell(i_por_rst_n) |-> ##[1:6] o_init_por; endproperty
  a_por: assert property (p_por) else $error("power pin");
  property p_miss; calm && i_unified_xlate_buffer_miss && i_fault.valid && !o_status_word[28] && !mh
    && !i_gen_exc |=> o_pc_load && !ini && o_status_word[30:28] == 3'h7
    && o_status_word[7:4] == $past(o_status_word[7:4]); endproperty
  a_miss: assert property (p_miss) else $error("miss entry");
  c_miss: cover property (calm && i_unified_xlate_buffer_miss);
  c_por: cover property (o_init_por);
  c_man: cover property (o_init_manual);
endmodule : rxe_entry_props

/* File: tb/rxe_far_side.sv */
module rxe_far_side (
  // bench request
  input wire logic [2:0] i_sel,
  input wire logic i_go,
  // pins and event lines
  output logic o_por_n,
  output logic o_man_n,
  output logic o_trst_n,
  output logic [4:0] o_ev
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins are pulled up; power-on drags manual too, both let go together
  assign o_por_n = !(i_go && i_sel == 3'h5);
  assign o_man_n = !(i_go && (i_sel == 3'h5 || i_sel == 3'h6));
  assign o_trst_n = o_por_n;
  assign o_ev = i_go ? 5'(1 << i_sel) : 5'h0;
endmodule : rxe_far_side

/* File: tb/test_reset_and_tlb_exception_entry.sv */
`include "rxe_cfg.svh"
module test_reset_and_tlb_exception_entry;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [2:0] sel = 3'h0;
  logic go = 1'b0;
  logic ubrk = 1'b0;
  rxe_pkg::rxe_fault_s flt = '0;
  rxe_pkg::rxe_wb_req_s wbr = '0;
  logic por_n, man_n, ack, pcl, ip, im, lp, lm;
  logic [4:0] ev;
  logic [31:0] dat, pc, sw, lpc, q, v, s;
  int fail_count = 0;
  int checks_done = 0;
  int nload = 0;
  int n0;
  logic [2:0] tk [9] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h5, 3'h7, 3'h7};
  logic [3:0] td [9] = '{4'h2, 4'h3, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h6, 4'h7};
  logic [11:0] tc [9] = '{12'h0, 12'h20, 12'h20, 12'h140, 12'h140, 12'h20, 12'h0, 12'h0, 12'h0};
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  rxe_far_side u_far (.i_sel(sel), .i_go(go), .o_por_n(por_n), .o_man_n(man_n),
    .o_trst_n(), .o_ev(ev));
  rxe_entry u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_por_rst_n(por_n),
    .i_manual_rst_n(man_n), .i_wdt_overflow(ev[0]), .i_gen_exc(ev[1]), .i_user_break(ubrk),
    .i_instr_xlate_buffer_multi_hit(ev[2]), .i_unified_xlate_buffer_multi_hit(ev[3]), .i_unified_xlate_buffer_miss(ev[4]), .i_fault(flt),
    .i_wb(wbr), .o_wb_dat(dat), .o_wb_ack(ack), .o_pc_load(pcl), .o_pc(pc),
    .o_init_por(ip), .o_init_manual(im), .o_status_word(sw));
  always @(posedge i_clk) begin
    if (pcl === 1'b1) begin
      nload <= nload + 1;
      lp <= ip;
      lm <= im;
      lpc <= pc;
    end
  end
  // ----------
  // tasks
  // ----------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    wbr <= '{1'b1, 1'b1, we, 4'hf, a, d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat;
    wbr <= '0;
    if (ack !== 1'b1) begin
      chk("ack", 0, 1);
      finish_test();
    end
  endtask : wb
  task automatic rc(string nm, logic [7:0] a, logic [31:0] e, logic [31:0] m = 32'hffffffff);
    wb(1'b0, a, 32'h0);
    chk(nm, q & m, e);
  endtask : rc
  task automatic shot(logic [2:0] k, logic [3:0] d, logic [11:0] c, logic [31:0] e);
    int n;
    n0 = nload;
    if (k == 3'h7) begin
      wb(1'b1, `RXE_OFS_DBG, {28'h0, d});
    end else begin
      @(posedge i_clk);
      sel <= k;
      go <= 1'b1;
    end
    n = 0;
    while (nload == n0 && n < 16) begin
      @(posedge i_clk);
      if (k < 3'h5) go <= 1'b0;
      n++;
    end
    go <= 1'b0;
    if (nload == n0) begin
      chk("entry", 0, 1);
      finish_test();
    end
    chk("init", {lp, lm}, k == 3'h4 ? 2'h0 : c == 12'h0 ? 2'h2 : 2'h1);
    chk("pc", lpc, e);
    rc("event", `RXE_OFS_EVENT, {20'h0, c});
  endtask : shot
  // ----------
  // sequence
  // ----------
  initial begin
    void'($urandom(32'hf952));
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    chk("pc", pc, `RXE_RESET_VEC);
    chk("status", sw, `RXE_SW_RST);
    rc("event", `RXE_OFS_EVENT, 32'h0);
    rc("unmapped", 8'h3c, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      s = $urandom & 32'h600080f0;
      wb(1'b1, `RXE_OFS_VBASE, v);
      wb(1'b1, `RXE_OFS_STATUS, s);
      wb(1'b1, `RXE_OFS_PAGE_HI, v);
      flt <= '{1'b1, $urandom, i[0], $urandom, $urandom};
      shot(3'h4, 4'h0, i[0] ? `RXE_CODE_MISS_WR : `RXE_CODE_MISS_RD, v + `RXE_MISS_OFS);
      rc("fault", `RXE_OFS_FAULT, flt.vaddr);
      rc("page_num", `RXE_OFS_PAGE_HI, (flt.vaddr & 32'hfffffc00) | (v & 32'h000003ff));
      rc("saved_pc", `RXE_OFS_SAVED_PC, flt.pc);
      rc("saved_status", `RXE_OFS_SAVED_ST, s);
      rc("saved_gr15", `RXE_OFS_SAVED_GR, flt.gr15);
      rc("vbase", `RXE_OFS_VBASE, v);
      chk("status", sw, s | 32'h70000000);
    end
    $display("miss tests done");
    for (int i = 0; i < 9; i++) begin
      flt <= '{1'b1, $urandom, 1'b0, $urandom, $urandom};
      wb(1'b1, `RXE_OFS_VBASE, $urandom);
      wb(1'b1, `RXE_OFS_STATUS, 32'h10008000);
      wb(1'b1, `RXE_OFS_WDT, {28'h0, td[i]});
      shot(tk[i], td[i], tc[i], `RXE_RESET_VEC);
      rc("vbase", `RXE_OFS_VBASE, 32'h0);
      chk("status", sw & 32'h700080f0, 32'h700000f0);
      if (tc[i] == `RXE_CODE_MHIT) rc("fault", `RXE_OFS_FAULT, flt.vaddr);
    end
    $display("reset tests done");
    wb(1'b1, `RXE_OFS_STATUS, 32'h10000000);
    n0 = nload;
    ubrk <= 1'b1;
    sel <= 3'h1;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (8) @(posedge i_clk);
    ubrk <= 1'b0;
    chk("break", nload - n0, 0);
    $display("user break done");
    // block bit still set: a miss must escalate to a manual reset
    n0 = nload;
    sel <= 3'h4;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk("blocked miss", nload - n0, 1);
    chk("blocked init", {lp, lm}, 2'h1);
    rc("blocked event", `RXE_OFS_EVENT, {20'h0, `RXE_CODE_MAN});
    $display("blocked miss done");
    finish_test();
  end
endmodule : test_reset_and_tlb_exception_entry
bind rxe_entry rxe_entry_props u_props (.i_clk, .i_rstn, .i_por_rst_n, .i_manual_rst_n,
  .i_wdt_overflow, .i_gen_exc, .i_user_break, .i_instr_xlate_buffer_multi_hit, .i_unified_xlate_buffer_multi_hit,
  .i_unified_xlate_buffer_miss, .i_fault, .o_pc_load, .o_pc, .o_init_por, .o_init_manual, .o_status_word);
